/* phy_aux_defs.svh */
// offsets, field positions, reset values and timing constants of the config bank
`ifndef PHY_AUX_DEFS_SVH
`define PHY_AUX_DEFS_SVH

// register offsets, word addresses
`define REG_SLEEP_CG    16'h0487
`define REG_INTERLEAVE  16'h0489
`define REG_SLEEP_TMR   16'h0493
`define REG_JABBER      16'h0496
`define REG_TEST_PAT    16'h0497
`define REG_WAKE_CFG    16'h04a0
`define REG_IRQ_STAT    16'h04f0
`define REG_IRQ_MASK    16'h04f1

// reset values
`define RST_SLEEP_CG    16'h0a00
`define RST_INTERLEAVE  16'h0001
`define RST_SLEEP_TMR   16'h0014
`define RST_JABBER      16'h044c
`define RST_TEST_PAT    16'h01c0
`define RST_WAKE_CFG    16'h1000
`define RST_ZERO        16'h0000

// bits that software may change; others hold their reset value
`define WMASK_SLEEP_CG   16'hffff
`define WMASK_INTERLEAVE 16'h0007
`define WMASK_SLEEP_TMR  16'hffff
`define WMASK_JABBER     16'h07ff
`define WMASK_TEST_PAT   16'h03ff
`define WMASK_WAKE_CFG   16'hf7ff

// field positions
`define SCG_EN      0
`define IL_DET      0
`define IL_FOLLOW   1
`define IL_FORCE    2
`define TMR_LO      4
`define TMR_HI      5
`define JAB_HI      10
`define TM_LO       4
`define TM_HI       9
`define WK_MAGIC    0
`define WK_PAT      1
`define WK_EN       7
`define WK_LEVEL    8
`define WK_PW_LO    9
`define WK_PW_HI    10
`define WK_CLR      11
`define WK_CRC      12

// interrupt status layout
`define IRQ_JABBER  0
`define IRQ_WAKE    1
`define IRQ_BITS    2

// clock and timing
`define CLK_PERIOD_NS  100
`define CLK_MHZ        10
`define SLEEP_T0_US    400
`define SLEEP_T1_US    1000
`define SLEEP_T2_US    4000
`define SLEEP_T3_US    8000
`define US_TO_CYC(us)  ((us) * `CLK_MHZ)
`define WAKE_PW0_NS    80
`define WAKE_PW1_NS    160
`define WAKE_PW2_NS    320
`define WAKE_PW3_NS    640
`define NS_TO_CYC(ns)  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TM_MUL         2
`define TM_ADD         2

`endif

/* phy_aux_pkg.sv */
// shared types of the config bank
package phy_aux_pkg;
    // wake indicator states
    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_PULSE,
        WAKE_LEVEL
    } wake_state_t;
endpackage : phy_aux_pkg

/* wake_indicator.sv */
// wake-frame indication: qualifies hits and drives a pulse or a held level
`timescale 1ns/1ps
`include "phy_aux_defs.svh"

module wake_indicator (
    input  wire logic       mclk,        // core clock
    input  wire logic       rst_n,       // sync reset, low
    input  wire logic       magic_hit,   // magic packet seen, pulse
    input  wire logic       pattern_hit, // pattern frame seen, pulse
    input  wire logic       crc_bad,     // frame crc bad, with hit
    input  wire logic       wake_en,     // detection enabled
    input  wire logic       magic_en,    // magic hit enabled
    input  wire logic       pattern_en,  // pattern hit enabled
    input  wire logic       crc_gate,    // gate bad-crc frames
    input  wire logic       level_mode,  // 1 held level, 0 pulse
    input  wire logic [1:0] pulse_sel,   // pulse width code
    input  wire logic       level_clr,   // clear held level, pulse
    output logic            wake_out_q,  // wake indication
    output logic            wake_evt_q   // qualified event, pulse
);
    // pulse widths rounded up to whole core cycles
    localparam logic [2:0] PW0 = 3'(`NS_TO_CYC(`WAKE_PW0_NS));
    localparam logic [2:0] PW1 = 3'(`NS_TO_CYC(`WAKE_PW1_NS));
    localparam logic [2:0] PW2 = 3'(`NS_TO_CYC(`WAKE_PW2_NS));
    localparam logic [2:0] PW3 = 3'(`NS_TO_CYC(`WAKE_PW3_NS));

    phy_aux_pkg::wake_state_t state_q, state_d; // indicator state
    logic [2:0] cnt_q, cnt_d;                   // pulse cycles left
    logic       evt;                            // qualified hit
    logic [2:0] width;                          // chosen pulse width
    logic       wake_out_d;                     // next indication
    logic       wake_evt_d;                     // next event flag

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        evt = wake_en & ((magic_en & magic_hit) | (pattern_en & pattern_hit))
              & ~(crc_gate & crc_bad);
        unique case (pulse_sel)
            2'b00: width = PW0;
            2'b01: width = PW1;
            2'b10: width = PW2;
            2'b11: width = PW3;
        endcase
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            phy_aux_pkg::WAKE_IDLE: begin
                if (evt && level_mode) begin
                    state_d = phy_aux_pkg::WAKE_LEVEL;
                end else if (evt) begin
                    state_d = phy_aux_pkg::WAKE_PULSE;
                    cnt_d   = width - 3'h1;
                end
            end
            phy_aux_pkg::WAKE_PULSE: begin
                // a hit during a pulse is merged, not stretched
                if (cnt_q == 3'h0) begin
                    state_d = phy_aux_pkg::WAKE_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            phy_aux_pkg::WAKE_LEVEL: begin
                // a new hit in the clearing cycle keeps the level
                if (level_clr && !evt) begin
                    state_d = phy_aux_pkg::WAKE_IDLE;
                end
            end
        endcase
        wake_out_d = (state_d != phy_aux_pkg::WAKE_IDLE);
        wake_evt_d = evt;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q    <= phy_aux_pkg::WAKE_IDLE;
            cnt_q      <= 3'h0;
            wake_out_q <= 1'b0;
            wake_evt_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            wake_out_q <= wake_out_d;
            wake_evt_q <= wake_evt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_pulse_short: assert property ((state_q == phy_aux_pkg::WAKE_IDLE) && evt && !level_mode
        && pulse_sel == 2'b00 |=> wake_out_q ##1 !wake_out_q)
        else $error("shortest wake pulse not one cycle");
    a_pulse_long: assert property ((state_q == phy_aux_pkg::WAKE_IDLE) && evt && !level_mode
        && pulse_sel == 2'b11 |=> wake_out_q [*7] ##1 !wake_out_q)
        else $error("longest wake pulse not seven cycles");
    a_level_hold: assert property ((state_q == phy_aux_pkg::WAKE_IDLE) && evt && level_mode
        |=> wake_out_q [*3] or (wake_out_q ##[0:2] $past(level_clr)))
        else $error("wake level dropped without clear");
    a_crc_gated: assert property (crc_gate && crc_bad |=> !wake_evt_q)
        else $error("bad crc frame produced wake event");
endmodule : wake_indicator

/* phy_pcs_aux_config_regs.sv */
// auxiliary coding-sublayer config bank with jabber timer and interrupts
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "phy_aux_defs.svh"

// Summary of operation
// - sleep code-groups only while enable bit set
// - force bit turns transmit interleave on
// - follow bit: interleave once receive detects it
// - detection runs while enable bit is one
// - timer code picks 0.4, 1, 4, 8 ms
// - jabber once transmission exceeds programmed timeout
// - one timeout count equals one microsecond
// - test burst length is twice field plus two
// - mode bit selects held level or pulse
// - pulse width code gives 80..640 ns, rounded up to 1..7 core cycles
// - clear bit drops held level, self-clears
// - crc gate suppresses wake on bad frames
module phy_pcs_aux_config_regs #(
    parameter int SLEEP_T0_CYC = `US_TO_CYC(`SLEEP_T0_US), // 0.4 ms in cycles
    parameter int SLEEP_T1_CYC = `US_TO_CYC(`SLEEP_T1_US), // 1 ms in cycles
    parameter int SLEEP_T2_CYC = `US_TO_CYC(`SLEEP_T2_US), // 4 ms in cycles
    parameter int SLEEP_T3_CYC = `US_TO_CYC(`SLEEP_T3_US)  // 8 ms in cycles
) (
    input  wire logic        mclk,             // core clock, 10 MHz
    input  wire logic        rst_n,            // sync reset, low
    input  wire logic [15:0] addr,             // register address
    input  wire logic [15:0] wr_data,          // write data
    input  wire logic        wr_stb,           // write strobe
    input  wire logic        rd_stb,           // read strobe
    output logic      [15:0] rd_data_q,        // read data, next cycle
    input  wire logic        rx_interleave_seen, // receive saw interleave
    input  wire logic        tx_active,        // transmission in progress
    input  wire logic        magic_hit,        // magic packet seen
    input  wire logic        pattern_hit,      // pattern frame seen
    input  wire logic        crc_bad,          // frame crc bad
    output logic             sleep_codegroup_enable_q, // sleep code-groups on
    output logic             rx_interleave_detect_q,   // detection on
    output logic             tx_interleave_q,  // transmit interleave on
    output logic      [16:0] sleep_timer_cyc_q, // sleep timer length
    output logic      [14:0] jabber_limit_q,   // jabber limit in cycles
    output logic             jabber_q,         // jabber condition
    output logic      [7:0]  tm1_burst_len_q,  // test mode 1 symbols, up to 128
    output logic             wake_frame_detect_q, // wake indication
    output logic             irq_q             // interrupt, high level
);
    // register storage
    logic [15:0] scg_q, scg_d;       // sleep_codegroup_control
    logic [15:0] il_q, il_d;         // interleave_config
    logic [15:0] tmr_q, tmr_d;       // sleep_request_timer_control
    logic [15:0] jab_q, jab_d;       // jabber_timeout_config
    logic [15:0] tp_q, tp_d;         // test_pattern_control
    logic [15:0] wk_q, wk_d;         // wake_frame_config
    logic [`IRQ_BITS-1:0] stat_q, stat_d; // sticky events
    logic [`IRQ_BITS-1:0] mask_q, mask_d; // interrupt enables
    logic [15:0] rd_data_d;          // next read data
    logic        wk_clr;             // level clear pulse

    // derived control
    logic        tx_il_d;            // next transmit interleave
    logic [16:0] tmr_cyc_d;          // next timer length
    logic [14:0] jab_lim_d;          // next jabber limit
    logic [7:0]  tm_len_d;           // next burst length
    logic        irq_d;              // next interrupt

    // jabber detector
    logic [14:0] jcnt_q, jcnt_d;     // active cycles so far
    logic        jabber_d;           // next jabber flag
    logic        jab_evt;            // jabber onset

    logic        wake_evt;           // qualified wake event

    // write decodes and the status read decode
    logic wr_scg, wr_il, wr_tmr, wr_jab, wr_tp, wr_wk, wr_mask, rd_stat;

    // keep read-only bits, take writable ones
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] wmask);
        merge = (new_v & wmask) | (old_v & ~wmask);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // address decode
    always_comb begin
        wr_scg  = wr_stb && (addr == `REG_SLEEP_CG);
        wr_il   = wr_stb && (addr == `REG_INTERLEAVE);
        wr_tmr  = wr_stb && (addr == `REG_SLEEP_TMR);
        wr_jab  = wr_stb && (addr == `REG_JABBER);
        wr_tp   = wr_stb && (addr == `REG_TEST_PAT);
        wr_wk   = wr_stb && (addr == `REG_WAKE_CFG);
        wr_mask = wr_stb && (addr == `REG_IRQ_MASK);
        rd_stat = rd_stb && (addr == `REG_IRQ_STAT);
        // the clear bit is never stored, so it reads zero
        wk_clr  = wr_wk && wr_data[`WK_CLR];
    end

    ////////////////////////////////////////////////////////////////////////
    // register next values
    always_comb begin
        scg_d  = wr_scg ? merge(scg_q, wr_data, `WMASK_SLEEP_CG) : scg_q;
        il_d   = wr_il  ? merge(il_q,  wr_data, `WMASK_INTERLEAVE) : il_q;
        tmr_d  = wr_tmr ? merge(tmr_q, wr_data, `WMASK_SLEEP_TMR) : tmr_q;
        jab_d  = wr_jab ? merge(jab_q, wr_data, `WMASK_JABBER) : jab_q;
        tp_d   = wr_tp  ? merge(tp_q,  wr_data, `WMASK_TEST_PAT) : tp_q;
        wk_d   = wr_wk  ? merge(wk_q,  wr_data, `WMASK_WAKE_CFG) : wk_q;
        mask_d = wr_mask ? wr_data[`IRQ_BITS-1:0] : mask_q;
        // read clears, but an event in the same cycle survives
        stat_d = rd_stat ? {`IRQ_BITS{1'b0}} : stat_q;
        stat_d[`IRQ_JABBER] = stat_d[`IRQ_JABBER] | jab_evt;
        stat_d[`IRQ_WAKE]   = stat_d[`IRQ_WAKE] | wake_evt;
        irq_d = |(stat_q & mask_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, unmapped addresses read zero
    always_comb begin
        rd_data_d = `RST_ZERO;
        if (rd_stb) begin
            unique case (addr)
                `REG_SLEEP_CG:   rd_data_d = scg_q;
                `REG_INTERLEAVE: rd_data_d = il_q;
                `REG_SLEEP_TMR:  rd_data_d = tmr_q;
                `REG_JABBER:     rd_data_d = jab_q;
                `REG_TEST_PAT:   rd_data_d = tp_q;
                `REG_WAKE_CFG:   rd_data_d = wk_q;
                `REG_IRQ_STAT:   rd_data_d = 16'(stat_q);
                `REG_IRQ_MASK:   rd_data_d = 16'(mask_q);
                default:         rd_data_d = `RST_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control decode toward the datapath units
    always_comb begin
        // force wins; follow waits for the receive side to see it
        tx_il_d = il_q[`IL_FORCE]
                | (il_q[`IL_FOLLOW] & il_q[`IL_DET] & rx_interleave_seen);
        unique case (tmr_q[`TMR_HI:`TMR_LO])
            2'b00: tmr_cyc_d = 17'(SLEEP_T0_CYC);
            2'b01: tmr_cyc_d = 17'(SLEEP_T1_CYC);
            2'b10: tmr_cyc_d = 17'(SLEEP_T2_CYC);
            2'b11: tmr_cyc_d = 17'(SLEEP_T3_CYC);
        endcase
        jab_lim_d = 15'(jab_q[`JAB_HI:0]) * 15'(`CLK_MHZ);
        // full field gives 128, one past seven bits
        tm_len_d  = 8'(`TM_MUL) * 8'(tp_q[`TM_HI:`TM_LO]) + 8'(`TM_ADD);
    end

    ////////////////////////////////////////////////////////////////////////
    // jabber detector: flags once transmit outlasts the limit
    always_comb begin
        // counter saturates; the largest limit stays well below its top
        if (!tx_active) begin
            jcnt_d = 15'h0000;
        end else if (jcnt_q != 15'h7fff) begin
            jcnt_d = jcnt_q + 15'h0001;
        end else begin
            jcnt_d = jcnt_q;
        end
        // jcnt_q earlier active cycles plus this one exceed the limit
        jabber_d = tx_active && (jcnt_q >= jabber_limit_q);
        jab_evt  = jabber_d && !jabber_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // all registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scg_q  <= `RST_SLEEP_CG;
            il_q   <= `RST_INTERLEAVE;
            tmr_q  <= `RST_SLEEP_TMR;
            jab_q  <= `RST_JABBER;
            tp_q   <= `RST_TEST_PAT;
            wk_q   <= `RST_WAKE_CFG;
            stat_q <= {`IRQ_BITS{1'b0}};
            mask_q <= {`IRQ_BITS{1'b0}};
            rd_data_q <= `RST_ZERO;
            sleep_codegroup_enable_q <= 1'b0;
            rx_interleave_detect_q   <= 1'b1;
            tx_interleave_q   <= 1'b0;
            sleep_timer_cyc_q <= 17'(SLEEP_T1_CYC);
            jabber_limit_q    <= 15'(`RST_JABBER) * 15'(`CLK_MHZ);
            tm1_burst_len_q   <= 8'(`TM_MUL) * 8'(`RST_TEST_PAT >> `TM_LO) + 8'(`TM_ADD);
            jcnt_q   <= 15'h0000;
            jabber_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            scg_q  <= scg_d;
            il_q   <= il_d;
            tmr_q  <= tmr_d;
            jab_q  <= jab_d;
            tp_q   <= tp_d;
            wk_q   <= wk_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rd_data_q <= rd_data_d;
            sleep_codegroup_enable_q <= scg_d[`SCG_EN];
            rx_interleave_detect_q   <= il_d[`IL_DET];
            tx_interleave_q   <= tx_il_d;
            sleep_timer_cyc_q <= tmr_cyc_d;
            jabber_limit_q    <= jab_lim_d;
            tm1_burst_len_q   <= tm_len_d;
            jcnt_q   <= jcnt_d;
            jabber_q <= jabber_d;
            irq_q    <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake indication unit
    wake_indicator u_wake (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .magic_hit   (magic_hit),
        .pattern_hit (pattern_hit),
        .crc_bad     (crc_bad),
        .wake_en     (wk_q[`WK_EN]),
        .magic_en    (wk_q[`WK_MAGIC]),
        .pattern_en  (wk_q[`WK_PAT]),
        .crc_gate    (wk_q[`WK_CRC]),
        .level_mode  (wk_q[`WK_LEVEL]),
        .pulse_sel   (wk_q[`WK_PW_HI:`WK_PW_LO]),
        .level_clr   (wk_clr),
        .wake_out_q  (wake_frame_detect_q),
        .wake_evt_q  (wake_evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_scg_enable: assert property (wr_scg |=> sleep_codegroup_enable_q == $past(wr_data[0]))
        else $error("sleep code-group enable not taken from write");
    a_force_il: assert property (il_q[`IL_FORCE] |=> tx_interleave_q)
        else $error("forced interleave not on");
    a_follow_il: assert property (!il_q[`IL_FORCE] && il_q[`IL_FOLLOW] && il_q[`IL_DET]
        |=> tx_interleave_q == $past(rx_interleave_seen))
        else $error("interleave does not follow receive detection");
    a_normal_il: assert property (!il_q[`IL_FORCE] && !il_q[`IL_FOLLOW] |=> !tx_interleave_q)
        else $error("interleave on in normal operation");
    a_det_write: assert property (wr_il |=> rx_interleave_detect_q == $past(wr_data[0]))
        else $error("detection enable not taken from write");
    a_timer_sel: assert property (wr_tmr && wr_data[5:4] == 2'b00
        |=> ##1 sleep_timer_cyc_q == 17'(SLEEP_T0_CYC))
        else $error("shortest sleep timer not selected");
    a_jabber_time: assert property ($rose(jabber_q)
        |-> $past(jcnt_q) == 15'($past(jab_q[10:0])) * 15'd10)
        else $error("jabber declared at wrong time");
    a_jab_scale: assert property (wr_jab |=> ##1 jabber_limit_q
        == 15'($past(wr_data[10:0], 2)) * 15'd10)
        else $error("jabber limit not ten cycles per count");
    a_burst_len: assert property (wr_tp |=> ##1 tm1_burst_len_q
        == 8'd2 * 8'($past(wr_data[9:4], 2)) + 8'd2)
        else $error("test burst length wrong");
    a_clr_reads0: assert property (rd_stb && addr == `REG_WAKE_CFG |=> !rd_data_q[11])
        else $error("self-clearing bit reads one");
    a_rsvd_read: assert property (rd_stb && addr == `REG_INTERLEAVE |=> rd_data_q[15:3] == 13'h0)
        else $error("reserved interleave bits not zero");
    a_irq_level: assert property (|(stat_q & mask_q) |=> irq_q)
        else $error("unmasked status without interrupt");
endmodule : phy_pcs_aux_config_regs

/* tb_phy_pcs_aux_config_regs.sv */
// self-checking bench of the auxiliary config bank, driven over its register port
`timescale 1ns/1ps
`include "phy_aux_defs.svh"

module testbench;
    logic        mclk;               // core clock, 10 MHz
    logic        rst_n;              // sync reset, low
    logic [15:0] addr;               // register address
    logic [15:0] wr_data;            // write data
    logic        wr_stb;             // write strobe
    logic        rd_stb;             // read strobe
    logic [15:0] rd_data_q;          // read data
    logic        rx_interleave_seen; // receive saw interleave
    logic        tx_active;          // transmission running
    logic        magic_hit;          // magic frame hit
    logic        pattern_hit;        // pattern frame hit
    logic        crc_bad;            // bad crc beside a hit
    logic        scg_en, det, tx_il, jab, wake, irq; // single-bit outputs
    logic [16:0] tmr;                // sleep timer length
    logic [14:0] jlim;               // jabber limit
    logic [7:0]  burst;              // test burst length
    int          error_cnt = 0;      // mismatches
    int          total_checks = 0;   // comparisons
    int          cyc = 0;            // cycle count for the hang guard
    int          n;                  // scratch count
    logic [15:0] d;                  // scratch read value
    logic [15:0] adr [6] = '{`REG_SLEEP_CG, `REG_INTERLEAVE, `REG_SLEEP_TMR,
                             `REG_JABBER, `REG_TEST_PAT, `REG_WAKE_CFG}; // bank offsets
    logic [15:0] rstv [6] = '{`RST_SLEEP_CG, `RST_INTERLEAVE, `RST_SLEEP_TMR,
                              `RST_JABBER, `RST_TEST_PAT, `RST_WAKE_CFG}; // reset values
    logic [15:0] wmsk [6] = '{16'hffff, 16'h0007, 16'hffff, 16'h07ff, 16'h03ff,
                              16'hf7ff}; // writable bits
    int          tmr_cyc [4] = '{4, 10, 40, 80};  // timer lengths at the small parameters
    int          pw_cyc [4] = '{1, 2, 4, 7};      // pulse widths in mclk cycles

    // small timer counts keep the run short; expectations use the same values
    phy_pcs_aux_config_regs #(.SLEEP_T0_CYC(4), .SLEEP_T1_CYC(10), .SLEEP_T2_CYC(40),
                              .SLEEP_T3_CYC(80)) DUT (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data_q(rd_data_q), .rx_interleave_seen(rx_interleave_seen),
        .tx_active(tx_active), .magic_hit(magic_hit), .pattern_hit(pattern_hit),
        .crc_bad(crc_bad), .sleep_codegroup_enable_q(scg_en), .rx_interleave_detect_q(det),
        .tx_interleave_q(tx_il), .sleep_timer_cyc_q(tmr), .jabber_limit_q(jlim),
        .jabber_q(jab), .tm1_burst_len_q(burst), .wake_frame_detect_q(wake), .irq_q(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the ceiling is well above the few hundred cycles used
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare, bus cycles and frame hits
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick
    // strobe for one cycle, then a gap cycle so no signal is driven twice per step
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge mclk);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        chk(17'(rd_data_q), 17'(exp));
    endtask : rchk
    // one-cycle hit, then count the cycles of wake indication over a window
    task automatic hit(input logic pat, input logic bad, output int cnt);
        @(posedge mclk);
        magic_hit <= !pat;
        pattern_hit <= pat;
        crc_bad <= bad;
        @(posedge mclk);
        magic_hit <= 1'b0;
        pattern_hit <= 1'b0;
        crc_bad <= 1'b0;
        cnt = 0;
        // the indication rises at this very edge, so sample before waiting
        repeat (20) begin
            #1;
            if (wake === 1'b1) cnt++;
            @(posedge mclk);
        end
        #1;
    endtask : hit
    task automatic results;
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, wr_stb, rd_stb, rx_interleave_seen, tx_active} = '0;
        {magic_hit, pattern_hit, crc_bad, addr, wr_data} = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        tick(1);
        chk(17'(scg_en), 17'(0));
        chk(17'(det), 17'(1));
        chk(tmr, 17'(10));
        chk(17'(jlim), 17'(11000));
        chk(17'(burst), 17'(58));
        for (int i = 0; i < 6; i++) rchk(adr[i], rstv[i]);
        rchk(`REG_IRQ_STAT, 16'h0000);
        wr(16'h0488, 16'hffff);
        rchk(16'h0488, 16'h0000);
        // all ones then all zeros: read-only and self-clearing bits must not stick
        for (int i = 0; i < 6; i++) begin
            wr(adr[i], 16'hffff);
            rchk(adr[i], (rstv[i] & ~wmsk[i]) | wmsk[i]);
            wr(adr[i], 16'h0000);
            rchk(adr[i], rstv[i] & ~wmsk[i]);
        end
        tick(2);
        chk(17'(scg_en), 17'(0));
        chk(17'(det), 17'(0));
        wr(`REG_SLEEP_CG, 16'h0001);
        tick(1);
        chk(17'(scg_en), 17'(1));
        // interleave: follow waits for receive detection, force acts alone
        wr(`REG_INTERLEAVE, 16'h0003);
        tick(3);
        chk(17'(tx_il), 17'(0));
        rx_interleave_seen <= 1'b1;
        tick(3);
        chk(17'(tx_il), 17'(1));
        wr(`REG_INTERLEAVE, 16'h0002);
        tick(3);
        chk(17'(tx_il), 17'(0));
        rx_interleave_seen <= 1'b0;
        wr(`REG_INTERLEAVE, 16'h0004);
        tick(3);
        chk(17'(tx_il), 17'(1));
        for (int c = 0; c < 4; c++) begin
            wr(`REG_SLEEP_TMR, 16'(c << 4) | 16'h0004);
            tick(2);
            chk(tmr, 17'(tmr_cyc[c]));
        end
        wr(`REG_TEST_PAT, 16'h0000);
        tick(2);
        chk(17'(burst), 17'(2));
        wr(`REG_TEST_PAT, 16'h03f0);
        tick(2);
        chk(17'(burst), 17'(128));
        // jabber: limit 20 cycles, must exceed it, then raise the interrupt
        wr(`REG_IRQ_MASK, 16'h0003);
        wr(`REG_JABBER, 16'h0002);
        tick(2);
        chk(17'(jlim), 17'(20));
        @(posedge mclk);
        tx_active <= 1'b1;
        #1;
        n = 0;
        while (jab !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk(17'(n), 17'(21));
        tick(3);
        chk(17'(irq), 17'(1));
        tx_active <= 1'b0;
        rchk(`REG_IRQ_STAT, 16'h0001);
        tick(2);
        chk(17'(irq), 17'(0));
        chk(17'(jab), 17'(0));
        // wake pulse widths for every code, each event also latches status
        for (int c = 0; c < 4; c++) begin
            wr(`REG_WAKE_CFG, 16'h1081 | 16'(c << 9));
            hit(1'b0, 1'b0, n);
            chk(17'(n), 17'(pw_cyc[c]));
            chk(17'(irq), 17'(1));
            rchk(`REG_IRQ_STAT, 16'h0002);
        end
        hit(1'b0, 1'b1, n);
        chk(17'(n), 17'(0));
        hit(1'b1, 1'b0, n);
        chk(17'(n), 17'(0));
        wr(`REG_WAKE_CFG, 16'h1082);
        hit(1'b1, 1'b0, n);
        chk(17'(n), 17'(1));
        wr(`REG_WAKE_CFG, 16'h0081);
        hit(1'b0, 1'b1, n);
        chk(17'(n), 17'(1));
        // masked wake still latches status but leaves the interrupt low
        wr(`REG_IRQ_MASK, 16'h0001);
        rchk(`REG_IRQ_STAT, 16'h0002);
        hit(1'b0, 1'b0, n);
        chk(17'(irq), 17'(0));
        rchk(`REG_IRQ_STAT, 16'h0002);
        // level mode holds until the self-clearing bit is written
        wr(`REG_WAKE_CFG, 16'h1181);
        hit(1'b0, 1'b0, n);
        chk(17'(n), 17'(20));
        wr(`REG_WAKE_CFG, 16'h1981);
        tick(2);
        chk(17'(wake), 17'(0));
        rchk(`REG_WAKE_CFG, 16'h1181);
        results();
    end
endmodule : testbench
